// file: verilog/clt_pkg.sv
// Shared constants and types for the configurable logic tile.
package clt_pkg;

    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned TILE_INPUTS   = 4;
    localparam int unsigned LUT_INPUTS    = 3;
    localparam int unsigned LUT_ENTRIES   = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0]  OFS_CFG       = 8'h00;
    localparam logic [7:0]  OFS_TRUTH     = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register field positions.
    localparam int unsigned CFG_MODE_LSB  = 0;
    localparam int unsigned CFG_ASYNC_LSB = 2;
    localparam int unsigned CFG_INV_LSB   = 4;
    localparam int unsigned CFG_LOCAL_BIT = 8;
    localparam int unsigned CFG_LONG_BIT  = 9;
    localparam int unsigned CFG_W         = 10;

    // Status register field positions.
    localparam int unsigned STA_STATE_BIT = 0;
    localparam int unsigned STA_LOCAL_BIT = 1;
    localparam int unsigned STA_LONG_BIT  = 2;
    localparam int unsigned STA_IN_LSB    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [9:0]  CFG_RESET     = 10'h300;
    localparam logic [7:0]  TRUTH_RESET   = 8'h00;

    typedef enum logic [1:0] {
        MODE_COMB  = 2'b00,
        MODE_LATCH = 2'b01,
        MODE_DFF   = 2'b10,
        MODE_EDFF  = 2'b11
    } clt_mode_t;

    typedef enum logic [1:0] {
        ASYNC_NONE   = 2'b00,
        ASYNC_CLEAR  = 2'b01,
        ASYNC_PRESET = 2'b10,
        ASYNC_RSVD   = 2'b11
    } clt_async_t;

endpackage : clt_pkg

// file: verilog/clt_tile.sv
// Configurable logic tile with its configuration registers on APB.
// Input use per storage mode (after inversion; a, b, c index the truth table in combinational mode): a = tile_in[0] data, b = tile_in[1]
// gate or tile clock, c = tile_in[2] clear/set (latch, flop) or enable,
// d = tile_in[3] clear/set of the enabled flop.
module clt_tile
#(
    parameter int unsigned AW = clt_pkg::ADDR_W
)(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [AW-1:0]                paddr,
    input  wire logic [clt_pkg::DATA_W-1:0]   pwdata,
    output logic      [clt_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [clt_pkg::TILE_INPUTS-1:0] tile_in,
    output logic                              neighbour_output,
    output logic                              long_route_output
);
    import clt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    function automatic logic addr_is(input logic [AW-1:0] a, input logic [7:0] ofs);
        addr_is = (a == AW'(ofs));
    endfunction : addr_is

    logic [CFG_W-1:0]       cfg_q;
    logic [LUT_ENTRIES-1:0] truth_q;
    logic                   state_q;
    logic                   state_d;
    logic                   clk_prev_q;
    logic                   nb_q;
    logic                   lr_q;
    logic [DATA_W-1:0]      prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;

    wire                    setup_phase = psel & ~penable;
    wire                    wr_fire     = psel & penable & pready_q & pwrite;
    wire                    hit_cfg     = addr_is(paddr, OFS_CFG);
    wire                    hit_truth   = addr_is(paddr, OFS_TRUTH);
    wire                    hit_status  = addr_is(paddr, OFS_STATUS);
    wire                    hit_any     = hit_cfg | hit_truth | hit_status;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields.
    wire clt_mode_t         mode      = clt_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
    wire clt_async_t        akind     = clt_async_t'(cfg_q[CFG_ASYNC_LSB +: 2]);
    wire [TILE_INPUTS-1:0]  inv       = cfg_q[CFG_INV_LSB +: TILE_INPUTS];
    wire                    drv_local = cfg_q[CFG_LOCAL_BIT];
    wire                    drv_long  = cfg_q[CFG_LONG_BIT];

    // Inversion is absorbed ahead of every use of an input in the tile logic; the status word reports the raw pins.
    wire [TILE_INPUTS-1:0]  x         = tile_in ^ inv;

    wire [LUT_INPUTS-1:0]   lut_idx   = x[LUT_INPUTS-1:0];
    wire                    lut_val   = truth_q[lut_idx];

    // The enabled flop frees input c for enable, so its clear/set moves to d.
    wire                    async_in  = (mode == MODE_EDFF) ? x[3] : x[2];
    wire                    storage   = (mode != MODE_COMB);
    wire                    clr_act   = storage & (akind == ASYNC_CLEAR) & async_in;
    wire                    pre_act   = storage & (akind == ASYNC_PRESET) & async_in;
    // The tile clock is input b seen at pclk rate. Its edge detector resets low, the idle
    // level of an uninverted pin, so no false edge follows reset. Changing the inversion
    // of b can itself make an edge, so reconfigure with b at rest.
    wire                    clk_rise  = x[1] & ~clk_prev_q;
    wire                    edff_en   = x[2];

    // The latch is transparent at pclk granularity: a gate pulse that spans no pclk
    // rising edge is not seen.
    logic                   capture;
    always_comb
    begin
        case (mode)
            MODE_LATCH: capture = x[1];
            MODE_DFF:   capture = clk_rise;
            MODE_EDFF:  capture = clk_rise & edff_en;
            default:    capture = 1'b0;
        endcase
    end

    // Clear beats preset beats capture; without them the cell holds.
    assign state_d = clr_act ? 1'b0 :
                     pre_act ? 1'b1 :
                     capture ? x[0] :
                               state_q;

    wire tile_val  = (mode == MODE_COMB) ? lut_val : state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Read data.
    logic [DATA_W-1:0] status_word;
    always_comb
    begin
        status_word                            = '0;
        status_word[STA_STATE_BIT]             = state_q;
        status_word[STA_LOCAL_BIT]             = nb_q;
        status_word[STA_LONG_BIT]              = lr_q;
        status_word[STA_IN_LSB +: TILE_INPUTS] = tile_in;
    end
    wire [DATA_W-1:0] rd_mux = hit_cfg   ? {{(DATA_W-CFG_W){1'b0}}, cfg_q} :
                               hit_truth ? {{(DATA_W-LUT_ENTRIES){1'b0}}, truth_q} :
                               hit_status ? status_word : '0;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access, answer ready in the access cycle.
    // Read data is forced to zero outside the answer so that a stale word can never
    // be mistaken for a fresh one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup_phase;
            prdata_q  <= (setup_phase & ~pwrite) ? rd_mux : '0;
            pslverr_q <= setup_phase & ~hit_any;
        end
    end

    // Writes land only at the access edge; a write to the read-only status word or to an
    // unmapped address changes nothing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q   <= CFG_RESET;
            truth_q <= TRUTH_RESET;
        end
        else
        begin
            if (wr_fire & hit_cfg)
                cfg_q <= pwdata[CFG_W-1:0];
            if (wr_fire & hit_truth)
                truth_q <= pwdata[LUT_ENTRIES-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tile storage and routed outputs.
    // Both routed outputs may be enabled at once; a route that is off stays low so that
    // it cannot disturb the lines it would otherwise drive.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= 1'b0;
            clk_prev_q <= 1'b0;
            nb_q       <= 1'b0;
            lr_q       <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            clk_prev_q <= x[1];
            nb_q       <= drv_local & tile_val;
            lr_q       <= drv_long & tile_val;
        end
    end

    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign neighbour_output  = nb_q;
    assign long_route_output = lr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the tile behaviour. They sample at pclk, so they see the tile as its
    // users do, one registered stage after the inputs.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The truth table entry picked straight from the raw pins and the inversion field.
    wire raw_lut_val = truth_q[tile_in[LUT_INPUTS-1:0] ^ cfg_q[CFG_INV_LSB +: LUT_INPUTS]];

    AST_LUT_OUT: assert property (
        (mode == MODE_COMB && drv_local && !wr_fire) |=> nb_q == $past(lut_val))
        else $error("combinational output does not follow the truth table");

    AST_LATCH: assert property (
        (mode == MODE_LATCH && !clr_act && !pre_act)
        |=> state_q == ($past(x[1]) ? $past(x[0]) : $past(state_q)))
        else $error("latch neither passed nor held its data");

    AST_DFF_EDGE: assert property (
        (mode == MODE_DFF && x[1] && !clk_prev_q && !clr_act && !pre_act)
        |=> state_q == $past(x[0]))
        else $error("flip-flop missed data on a tile clock edge");

    AST_EDFF_CAPT: assert property (
        (mode == MODE_EDFF && clk_rise && x[2] && !x[3]) |=> state_q == $past(x[0]))
        else $error("enabled flip-flop missed data with enable high");

    AST_INV_LUT: assert property (
        (mode == MODE_COMB && drv_local) |=> nb_q == $past(raw_lut_val))
        else $error("combinational output ignores input inversion");

    AST_INV_ASYNC: assert property (
        (mode == MODE_EDFF && akind == ASYNC_CLEAR && (tile_in[3] ^ cfg_q[CFG_INV_LSB + 3]))
        |=> !state_q)
        else $error("clear input of the enabled flip-flop not honoured");

    AST_ROUTE_OFF: assert property (
        (!drv_long && !wr_fire) |=> !lr_q [*2])
        else $error("long-route output driven while unrouted");

    AST_NO_ASYNC: assert property (
        (akind == ASYNC_NONE && storage && !capture) |=> $stable(state_q))
        else $error("storage changed without capture or async option");

    AST_CLEAR: assert property (
        (storage && akind == ASYNC_CLEAR && async_in) |=> !state_q)
        else $error("clear did not force zero");

    AST_PRESET: assert property (
        (storage && akind == ASYNC_PRESET && async_in) |=> state_q)
        else $error("preset did not force one");

    AST_EDFF_HOLD: assert property (
        (mode == MODE_EDFF && !x[2] && !clr_act && !pre_act) |=> $stable(state_q))
        else $error("enabled flip-flop changed with enable low");

    AST_NB_OFF: assert property (
        (!drv_local && !wr_fire) |=> !nb_q [*2])
        else $error("neighbour output driven while unrouted");

    AST_ROUTE_SAME: assert property (
        (drv_local && drv_long) |=> nb_q == lr_q)
        else $error("routed outputs disagree");

    AST_LATCH_CLR_C: assert property (
        (mode == MODE_LATCH && akind == ASYNC_CLEAR && x[2]) |=> !state_q)
        else $error("latch clear on input c did not force zero");

    AST_EDFF_C_FREE: assert property (
        (mode == MODE_EDFF && akind == ASYNC_CLEAR && x[2] && !x[3] && !clk_rise)
        |=> $stable(state_q))
        else $error("enabled flip-flop cleared from its enable input");

    AST_DFF_HOLD: assert property (
        (mode == MODE_DFF && !clk_rise && !clr_act && !pre_act) |=> $stable(state_q))
        else $error("flip-flop changed without a tile clock edge");

    AST_COMB_HOLD: assert property (
        (mode == MODE_COMB) |=> $stable(state_q))
        else $error("storage changed in combinational mode");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the register bus.
    wire [CFG_W-1:0]       wr_cfg_val   = pwdata[CFG_W-1:0];
    wire [LUT_ENTRIES-1:0] wr_truth_val = pwdata[LUT_ENTRIES-1:0];

    AST_APB_READY: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    AST_APB_ERR: assert property (
        (psel && !penable && !hit_any) |=> pslverr)
        else $error("unmapped address not flagged");

    AST_ERR_WITH_READY: assert property (
        pslverr |-> pready)
        else $error("error flag outside the answer cycle");

    AST_PRDATA_IDLE: assert property (
        !pready |-> prdata == '0)
        else $error("read data not zero outside the answer cycle");

    AST_CFG_WRITE: assert property (
        (wr_fire && hit_cfg) |=> cfg_q == $past(wr_cfg_val))
        else $error("configuration write did not land");

    AST_TRUTH_WRITE: assert property (
        (wr_fire && hit_truth) |=> truth_q == $past(wr_truth_val))
        else $error("truth table write did not land");

    AST_RO_WRITE: assert property (
        (wr_fire && !hit_cfg && !hit_truth) |=> $stable(cfg_q) && $stable(truth_q))
        else $error("write outside the writable registers changed state");

    COV_LUT:   cover property (mode == MODE_COMB && drv_local ##1 nb_q);
    COV_EDFF:  cover property (mode == MODE_EDFF && clk_rise && x[2] ##1 state_q);
    COV_CLEAR: cover property (state_q ##1 clr_act ##1 !state_q);
    COV_ERR:   cover property (pslverr);
    COV_PRESET: cover property (!state_q ##1 pre_act ##1 state_q);

endmodule : clt_tile

// file: bench/clt_tile_tb.sv
// Self-checking testbench for the configurable logic tile.
module clt_tile_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clt_pkg::*;

    logic                   pclk    = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel    = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite  = 1'b0;
    logic [ADDR_W-1:0]      paddr   = 8'h00;
    logic [DATA_W-1:0]      pwdata  = 32'h0;
    logic [DATA_W-1:0]      prdata;
    logic                   pready;
    logic                   pslverr;
    logic [TILE_INPUTS-1:0] tile_in = 4'h0;
    logic                   neighbour_output;
    logic                   long_route_output;
    logic [DATA_W-1:0]      rd;
    logic                   er;
    int                     n_mismatch = 0;
    int                     num_checks = 0;

    clt_tile i_clt_tile (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .tile_in           (tile_in),
        .neighbour_output  (neighbour_output),
        .long_route_output (long_route_output)
    );

    initial
    begin
        forever #20 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request is held until pready is seen high; data and error are taken at that edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16)
        begin
            chk("apb_timeout", 32'h1, 32'h0);
            stop_test();
        end
    endtask : apb

    // Three edges cover the input sample plus the registered output stage.
    task automatic tin(input logic [3:0] v);
        @(posedge pclk);
        tile_in <= v;
        repeat (3) @(posedge pclk);
    endtask : tin

    task automatic chk_out(input string nm, input logic el, input logic eg);
        chk({nm, "_local"}, {31'h0, el}, {31'h0, neighbour_output});
        chk({nm, "_long"}, {31'h0, eg}, {31'h0, long_route_output});
    endtask : chk_out

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, OFS_CFG, 32'h0);
        chk("cfg_reset", 32'h300, rd);
        chk("cfg_err", 32'h0, {31'h0, er});
        apb(1'b0, OFS_TRUTH, 32'h0);
        chk("truth_reset", 32'h0, rd);
        apb(1'b1, OFS_TRUTH, 32'hffffff5a);
        apb(1'b0, OFS_TRUTH, 32'h0);
        chk("truth_rw", 32'h5a, rd);
        apb(1'b1, OFS_STATUS, 32'hffffffff);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status_ro", 32'h0, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        $display("test regs done");
    endtask : t_regs

    task automatic t_comb();
        logic [7:0] tt;
        logic [2:0] iv;
        logic [2:0] x;
        tt = 8'he8;
        apb(1'b1, OFS_TRUTH, {24'h0, tt});
        for (int k = 0; k < 2; k++)
        begin
            iv = (k == 1) ? 3'h5 : 3'h0;
            apb(1'b1, OFS_CFG, {22'h0, 2'b11, 1'b0, iv, 4'h0});
            for (int v = 0; v < 8; v++)
            begin
                x = 3'(v);
                tin({x[0], x});
                chk_out("comb", tt[x ^ iv], tt[x ^ iv]);
            end
        end
        apb(1'b1, OFS_CFG, 32'h100);
        tin(4'h7);
        chk_out("route_near", 1'b1, 1'b0);
        apb(1'b1, OFS_CFG, 32'h200);
        tin(4'h7);
        chk_out("route_far", 1'b0, 1'b1);
        $display("test comb done");
    endtask : t_comb

    // Eight input nibbles, step 0 in the low nibble, with one expected output bit each.
    task automatic run(input string nm, input logic [31:0] cfg, input logic [31:0] seq,
                       input logic [7:0] exp);
        apb(1'b1, OFS_CFG, cfg);
        for (int i = 0; i < 8; i++)
        begin
            tin(seq[4*i +: 4]);
            chk_out(nm, exp[i], exp[i]);
        end
        $display("test %s done", nm);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_comb();
        run("dff_clear", 32'h306, 32'h75013104, 8'b00111000);
        run("dff_preset", 32'h30a, 32'h62040204, 8'b10110011);
        run("latch_clear", 32'h305, 32'h40320134, 8'b01101110);
        // The enabled flop's clear reaches it only on input d, as the global network would.
        run("edff_hold", 32'h307, 32'h64020758, 8'b01111100);
        run("edff_clear", 32'h307, 32'h5f75d575, 8'b00100110);
        run("dff_inv_clk", 32'h322, 32'h13ce5746, 8'b10011001);
        stop_test();
    end

endmodule : clt_tile_tb
